// *** design/sle_lamp_encoder.sv ***
// status lamp encoder: lamp patterns, torque cutoff record, register port and interrupt
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sle_regs.svh"

module sle_lamp_encoder #(
  parameter bit IS_CAP_MODULE = 1'b0,
  parameter int FLASH_HALF_CYCLES = `SLE_FLASH_HALF_MS * `SLE_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sle_pkg::sle_dev_state_t devState,
  input wire sle_pkg::sle_net_state_t netState,
  input wire logic dcLinkPresent,
  input wire logic safetySupplyPresent,
  input wire logic auxDelivered,
  input wire logic auxUndervoltage,
  input wire logic capCharged,
  input wire logic capCharging,
  input wire logic torqueCutoffIn,
  input wire logic [2:0] portLink,
  input wire logic [2:0] portActivity,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic unitLampGreen,
  output logic unitLampRed,
  output logic safetyLampGreen,
  output logic auxLampGreen,
  output logic auxLampRed,
  output logic networkLampGreen,
  output logic networkLampRed,
  output logic capacitorLampGreen,
  output logic [2:0] portLampGreen,
  output logic torqueCutoffOut,
  output logic torqueEnable,
  output logic irq
);

  localparam int NP = `SLE_PIN_COUNT;
  localparam int IW = `SLE_IRQ_WIDTH;

  typedef struct packed {
    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    logic [NP-1:0] prev;
    logic unitGreen;
    logic unitRed;
    logic safetyGreen;
    logic auxGreen;
    logic auxRed;
    logic netGreen;
    logic netRed;
    logic capGreen;
    logic [2:0] portGreen;
    logic cutoffLatched;
    logic cutoffOut;
    logic torqueOn;
    logic [IW-1:0] irqStatus;
    logic [IW-1:0] irqMask;
    logic irqOut;
    logic [31:0] rdata;
  } sle_enc_state_t;

  sle_enc_state_t st;
  sle_enc_state_t next_st;
  logic flashPhase;
  logic [NP-1:0] pinRaw;
  logic [2:0] next_portGreen;

  sle_flash_gen #(
    .HALF_CYCLES(FLASH_HALF_CYCLES)
  ) sle_flash_gen_inst (
    .clk(clk),
    .rst_n(rst_n),
    .flashPhase(flashPhase)
  );

  // gather the asynchronous pins into one vector for the synchroniser
  assign pinRaw = {portActivity, portLink, torqueCutoffIn, capCharging, capCharged,
                   auxUndervoltage, auxDelivered, safetySupplyPresent, dcLinkPresent};

  // one lamp per port; the capacitor module has no third port
  generate
    for (genvar p = 0; p < `SLE_PORT_COUNT; p++) begin : g_port
      always_comb begin
        if (IS_CAP_MODULE && p == 2) begin
          next_portGreen[p] = 1'b0;
        end else if (!st.sync2[`SLE_PIN_LINK_LSB + p]) begin
          next_portGreen[p] = 1'b0;
        end else if (st.sync2[`SLE_PIN_ACT_LSB + p]) begin
          next_portGreen[p] = flashPhase;
        end else begin
          next_portGreen[p] = 1'b1;
        end
      end
    end
  endgenerate

  // lamp encoding, cutoff record, events and register port
  always_comb begin
    logic [IW-1:0] events;
    logic [IW-1:0] clearBits;
    logic [2:0] linkFell;
    logic cutoffNow;
    events = '0;
    clearBits = '0;
    linkFell = '0;
    cutoffNow = 1'b0;
    next_st = st;
    // two flops on every pin before any logic reads it
    next_st.sync1 = pinRaw;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    next_st.unitGreen = 1'b0;
    next_st.unitRed = 1'b0;
    // fault outranks supply, supply outranks the normal green states
    if (devState == sle_pkg::SLE_DEV_FAULT || devState == sle_pkg::SLE_DEV_FAULT_REACTION) begin
      next_st.unitRed = 1'b1;
    end else if (!st.sync2[`SLE_PIN_DC]) begin
      next_st.unitRed = flashPhase;
    end else if (devState == sle_pkg::SLE_DEV_OP_ENABLED) begin
      next_st.unitGreen = 1'b1;
    end else if (devState == sle_pkg::SLE_DEV_STANDBY ||
                 devState == sle_pkg::SLE_DEV_POWER_UP) begin
      next_st.unitGreen = flashPhase;
    end
    next_st.safetyGreen = st.sync2[`SLE_PIN_SAFETY];
    // undervoltage wins over the green aux indication
    next_st.auxRed = !IS_CAP_MODULE && st.sync2[`SLE_PIN_UNDERVOLT];
    next_st.auxGreen = !IS_CAP_MODULE && !st.sync2[`SLE_PIN_UNDERVOLT] &&
                       st.sync2[`SLE_PIN_AUX];
    // network lamp, orange is both colours together
    next_st.netGreen = 1'b0;
    next_st.netRed = 1'b0;
    case (netState)
      sle_pkg::SLE_NET_MASTER: begin
        next_st.netGreen = 1'b1;
      end
      sle_pkg::SLE_NET_ONLINE: begin
        next_st.netGreen = 1'b1;
        next_st.netRed = 1'b1;
      end
      sle_pkg::SLE_NET_INIT_DONE: begin
        next_st.netRed = flashPhase;
      end
      sle_pkg::SLE_NET_ERROR: begin
        next_st.netRed = 1'b1;
      end
      default: begin
        next_st.netGreen = 1'b0;
      end
    endcase
    // capacitor charge, a change in progress outranks full charge
    if (!IS_CAP_MODULE) begin
      next_st.capGreen = 1'b0;
    end else if (st.sync2[`SLE_PIN_CHARGING]) begin
      next_st.capGreen = flashPhase;
    end else begin
      next_st.capGreen = st.sync2[`SLE_PIN_CHARGED];
    end
    next_st.portGreen = next_portGreen;
    // cutoff record cleared only by the controller, never while still active
    cutoffNow = st.sync2[`SLE_PIN_CUTOFF];
    if (cutoffNow) begin
      next_st.cutoffLatched = 1'b1;
    end else if (regWrite && regAddr == `SLE_ADDR_CTRL &&
                 regWdata[`SLE_CTRL_CUTOFF_RESET]) begin
      next_st.cutoffLatched = 1'b0;
    end
    // torque only when no cutoff is active or recorded
    next_st.torqueOn = !cutoffNow && !next_st.cutoffLatched;
    // forward down the chain, capacitor module is outside it
    next_st.cutoffOut = !IS_CAP_MODULE && (cutoffNow || next_st.cutoffLatched);
    // events taken from edges of the synchronised pins
    linkFell = st.prev[`SLE_PIN_LINK_LSB +: 3] & ~st.sync2[`SLE_PIN_LINK_LSB +: 3];
    events[`SLE_IRQ_CUTOFF] = cutoffNow && !st.prev[`SLE_PIN_CUTOFF];
    events[`SLE_IRQ_UNDERVOLT] = !IS_CAP_MODULE && st.sync2[`SLE_PIN_UNDERVOLT] &&
                                 !st.prev[`SLE_PIN_UNDERVOLT];
    events[`SLE_IRQ_DC_LOSS] = st.prev[`SLE_PIN_DC] && !st.sync2[`SLE_PIN_DC];
    events[`SLE_IRQ_LINK_LOSS] = |linkFell;
    // register writes; a new event wins over a clear in the same cycle
    if (regWrite && regAddr == `SLE_ADDR_IRQ_STATUS) begin
      clearBits = regWdata[IW-1:0];
    end else if (regWrite && regAddr == `SLE_ADDR_IRQ_MASK) begin
      next_st.irqMask = regWdata[IW-1:0];
    end
    next_st.irqStatus = (st.irqStatus & ~clearBits) | events;
    next_st.irqOut = |(next_st.irqStatus & next_st.irqMask);
    // register reads, data stand in the following cycle only
    next_st.rdata = 32'h0000_0000;
    if (regRead && regAddr == `SLE_ADDR_STATUS) begin
      next_st.rdata[NP-1:0] = st.sync2;
      next_st.rdata[`SLE_STATUS_LATCH] = st.cutoffLatched;
      next_st.rdata[`SLE_STATUS_TORQUE] = st.torqueOn;
    end else if (regRead && regAddr == `SLE_ADDR_IRQ_STATUS) begin
      next_st.rdata[IW-1:0] = st.irqStatus;
    end else if (regRead && regAddr == `SLE_ADDR_IRQ_MASK) begin
      next_st.rdata[IW-1:0] = st.irqMask;
    end
  end

  // state register; torque stays off until the first clean cycle after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // every output straight from the state register
  assign regRdata = st.rdata;
  assign unitLampGreen = st.unitGreen;
  assign unitLampRed = st.unitRed;
  assign safetyLampGreen = st.safetyGreen;
  assign auxLampGreen = st.auxGreen;
  assign auxLampRed = st.auxRed;
  assign networkLampGreen = st.netGreen;
  assign networkLampRed = st.netRed;
  assign capacitorLampGreen = st.capGreen;
  assign portLampGreen = st.portGreen;
  assign torqueCutoffOut = st.cutoffOut;
  assign torqueEnable = st.torqueOn;
  assign irq = st.irqOut;

  // checks on the encoder
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // a pin held for three edges has passed the synchroniser
  sequence cutoffHeld;
    torqueCutoffIn [*3];
  endsequence

  sequence safetyHeld;
    safetySupplyPresent [*3];
  endsequence

  sequence safetyGone;
    !safetySupplyPresent [*3];
  endsequence

  chk_op_green_steady: assert property (
    (devState == sle_pkg::SLE_DEV_OP_ENABLED && st.sync2[`SLE_PIN_DC])
    |=> (unitLampGreen && !unitLampRed))
    else $error("unit lamp not steady green in operation enabled");

  chk_standby_flash: assert property (
    ((devState == sle_pkg::SLE_DEV_STANDBY || devState == sle_pkg::SLE_DEV_POWER_UP)
     && st.sync2[`SLE_PIN_DC])
    |=> (unitLampGreen == $past(flashPhase) && !unitLampRed))
    else $error("unit lamp not flashing green in standby");

  chk_fault_red: assert property (
    (devState == sle_pkg::SLE_DEV_FAULT || devState == sle_pkg::SLE_DEV_FAULT_REACTION)
    |=> (unitLampRed && !unitLampGreen))
    else $error("unit lamp not steady red in fault");

  chk_dc_flash: assert property (
    (!st.sync2[`SLE_PIN_DC] && devState != sle_pkg::SLE_DEV_FAULT &&
     devState != sle_pkg::SLE_DEV_FAULT_REACTION)
    |=> (unitLampRed == $past(flashPhase) && !unitLampGreen))
    else $error("unit lamp not flashing red without dc link");

  chk_safety_on: assert property (
    safetyHeld |=> safetyLampGreen)
    else $error("safety lamp dark with supply present");

  chk_safety_off: assert property (
    safetyGone |=> !safetyLampGreen)
    else $error("safety lamp lit with supply absent");

  chk_aux_green: assert property (
    (st.sync2[`SLE_PIN_AUX] && !st.sync2[`SLE_PIN_UNDERVOLT])
    |=> (auxLampGreen == !IS_CAP_MODULE && !auxLampRed))
    else $error("aux lamp wrong while voltage delivered");

  chk_aux_red: assert property (
    st.sync2[`SLE_PIN_UNDERVOLT] |=> (auxLampRed == !IS_CAP_MODULE && !auxLampGreen))
    else $error("aux lamp not red on undervoltage");

  chk_port_steady: assert property (
    (st.sync2[`SLE_PIN_LINK_LSB] && !st.sync2[`SLE_PIN_ACT_LSB]) |=> portLampGreen[0])
    else $error("port lamp not steady with idle link");

  chk_port_nolink: assert property (
    !st.sync2[`SLE_PIN_LINK_LSB + 1] |=> !portLampGreen[1])
    else $error("port lamp lit without link");

  chk_cap_ports: assert property (
    IS_CAP_MODULE |-> !portLampGreen[2])
    else $error("third port lamp lit on capacitor module");

  chk_net_error: assert property (
    (netState == sle_pkg::SLE_NET_ERROR) |=> (networkLampRed && !networkLampGreen))
    else $error("network lamp not solid red on error");

  chk_net_online: assert property (
    (netState == sle_pkg::SLE_NET_ONLINE) |=> (networkLampRed && networkLampGreen))
    else $error("network lamp not orange when online");

  chk_cutoff_torque: assert property (
    cutoffHeld |=> (!torqueEnable ##1 !torqueEnable))
    else $error("torque enabled while cutoff active");

  chk_cutoff_forward: assert property (
    cutoffHeld |=> (torqueCutoffOut == !IS_CAP_MODULE))
    else $error("cutoff not forwarded down the chain");

  chk_cutoff_sticky: assert property (
    (st.cutoffLatched && !(regWrite && regAddr == `SLE_ADDR_CTRL)) |=> st.cutoffLatched)
    else $error("cutoff record dropped without controller reset");

  chk_cap_charged: assert property (
    (st.sync2[`SLE_PIN_CHARGED] && !st.sync2[`SLE_PIN_CHARGING])
    |=> (capacitorLampGreen == IS_CAP_MODULE))
    else $error("capacitor lamp not steady when charged");

endmodule : sle_lamp_encoder

`default_nettype wire

// *** design/sle_regs.svh ***
// register offsets, field positions, reset values and timing figures of the lamp encoder
`ifndef SLE_REGS_SVH
`define SLE_REGS_SVH

// register byte addresses
`define SLE_ADDR_CTRL 8'h00
`define SLE_ADDR_STATUS 8'h04
`define SLE_ADDR_IRQ_STATUS 8'h08
`define SLE_ADDR_IRQ_MASK 8'h0C

// control register fields
`define SLE_CTRL_CUTOFF_RESET 0

// interrupt status and mask fields
`define SLE_IRQ_WIDTH 4
`define SLE_IRQ_CUTOFF 0
`define SLE_IRQ_UNDERVOLT 1
`define SLE_IRQ_DC_LOSS 2
`define SLE_IRQ_LINK_LOSS 3
`define SLE_IRQ_MASK_RESET 4'h0
`define SLE_IRQ_STATUS_RESET 4'h0

// positions of the synchronised pins, also status register bits 12:0
`define SLE_PIN_COUNT 13
`define SLE_PIN_DC 0
`define SLE_PIN_SAFETY 1
`define SLE_PIN_AUX 2
`define SLE_PIN_UNDERVOLT 3
`define SLE_PIN_CHARGED 4
`define SLE_PIN_CHARGING 5
`define SLE_PIN_CUTOFF 6
`define SLE_PIN_LINK_LSB 7
`define SLE_PIN_ACT_LSB 10
`define SLE_PIN_RESET 13'h0000

// further status register bits
`define SLE_STATUS_LATCH 13
`define SLE_STATUS_TORQUE 14

// lamp port count and flash timing
`define SLE_PORT_COUNT 3
`define SLE_CLK_KHZ 50000
`define SLE_FLASH_HALF_MS 250

`endif

// *** design/sle_pkg.sv ***
// types shared by the lamp encoder files
package sle_pkg;

  // device state machine as seen by the lamps
  typedef enum logic [2:0] {
    SLE_DEV_POWER_UP,
    SLE_DEV_STANDBY,
    SLE_DEV_OP_ENABLED,
    SLE_DEV_FAULT_REACTION,
    SLE_DEV_FAULT,
    SLE_DEV_OTHER
  } sle_dev_state_t;

  // network condition for the network lamp
  typedef enum logic [2:0] {
    SLE_NET_OFF,
    SLE_NET_MASTER,
    SLE_NET_ONLINE,
    SLE_NET_INIT_DONE,
    SLE_NET_ERROR
  } sle_net_state_t;

endpackage : sle_pkg

// *** design/sle_flash_gen.sv ***
// free running flash phase generator for the lamps
`timescale 1ns/1ps
`default_nettype none

module sle_flash_gen #(
  parameter int HALF_CYCLES = 12500000
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic flashPhase
);

  localparam int CW = $clog2(HALF_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic phase;
  } sle_flash_state_t;

  sle_flash_state_t st;
  sle_flash_state_t next_st;

  // count one half period, then turn the phase round
  always_comb begin
    next_st = st;
    if (st.count == CW'(HALF_CYCLES - 1)) begin
      next_st.count = '0;
      next_st.phase = ~st.phase;
    end else begin
      next_st.count = st.count + CW'(1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flashPhase = st.phase;

endmodule : sle_flash_gen

`default_nettype wire

// *** test/sle_lamp_viewer.sv ***
// operator view of a lamp bank: each lamp judged off, steady, flashing or unclear
`timescale 1ns/1ps
`default_nettype none

module sle_lamp_viewer #(
  parameter int W = 11,
  parameter int WIN = 24
) (
  input wire logic clk,
  input wire logic [W-1:0] lamps
);
  // watch for WIN cycles; codes 0 off, 1 steady, 2 flashing, 3 unclear
  // flash versus steady
  task automatic observe(output logic [2*W-1:0] res);
    int onCnt [W];
    int tgl [W];
    logic [W-1:0] prev;
    #1;
    prev = lamps;
    onCnt = '{default: 0};
    tgl = '{default: 0};
    repeat (WIN) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < W; i++) begin
        onCnt[i] += int'(lamps[i]);
        tgl[i] += int'(lamps[i] != prev[i]);
      end
      prev = lamps;
    end
    // two toggles at least, so one late edge is not taken for a flash
    for (int i = 0; i < W; i++) begin
      res[2*i +: 2] = (tgl[i] > 1) ? 2'h2 : (onCnt[i] == WIN) ? 2'h1 :
        (onCnt[i] == 0) ? 2'h0 : 2'h3;
    end
  endtask : observe
endmodule : sle_lamp_viewer

`default_nettype wire

// *** test/sle_lamp_encoder_test.sv ***
// self-checking bench for the lamp encoder, access and capacitor builds side by side
`timescale 1ns/1ps
`default_nettype none
`include "sle_regs.svh"

module sle_lamp_encoder_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sle_pkg::sle_dev_state_t devState = sle_pkg::SLE_DEV_POWER_UP;
  sle_pkg::sle_net_state_t netState = sle_pkg::SLE_NET_OFF;
  logic dcLinkPresent = 1'b0, safetySupplyPresent = 1'b0, auxDelivered = 1'b0;
  logic auxUndervoltage = 1'b0, capCharged = 1'b0, capCharging = 1'b0;
  logic torqueCutoffIn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [2:0] portLink = 3'h0, portActivity = 3'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, rdA;
  logic [31:0] rdC;
  wire logic [10:0] lampA, lampC;
  logic cutA, cutC, tqA, tqC, irqA, irqC;
  int badCount = 0;
  int nCompared = 0;

  // short flash half period keeps the run brief
  sle_lamp_encoder #(.FLASH_HALF_CYCLES(4)) sle_lamp_encoder_inst (
    .clk, .rst_n, .devState, .netState, .dcLinkPresent, .safetySupplyPresent,
    .auxDelivered, .auxUndervoltage, .capCharged, .capCharging, .torqueCutoffIn,
    .portLink, .portActivity, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata(rdA), .unitLampGreen(lampA[0]), .unitLampRed(lampA[1]),
    .safetyLampGreen(lampA[2]), .auxLampGreen(lampA[3]), .auxLampRed(lampA[4]),
    .networkLampGreen(lampA[5]), .networkLampRed(lampA[6]),
    .capacitorLampGreen(lampA[7]), .portLampGreen(lampA[10:8]),
    .torqueCutoffOut(cutA), .torqueEnable(tqA), .irq(irqA));

  // capacitor build shares every input and the register writes; of its events only undervoltage differs
  sle_lamp_encoder #(.IS_CAP_MODULE(1'b1), .FLASH_HALF_CYCLES(4)) sle_lamp_encoder_cap_inst (
    .clk, .rst_n, .devState, .netState, .dcLinkPresent, .safetySupplyPresent,
    .auxDelivered, .auxUndervoltage, .capCharged, .capCharging, .torqueCutoffIn,
    .portLink, .portActivity, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata(rdC), .unitLampGreen(lampC[0]), .unitLampRed(lampC[1]),
    .safetyLampGreen(lampC[2]), .auxLampGreen(lampC[3]), .auxLampRed(lampC[4]),
    .networkLampGreen(lampC[5]), .networkLampRed(lampC[6]),
    .capacitorLampGreen(lampC[7]), .portLampGreen(lampC[10:8]),
    .torqueCutoffOut(cutC), .torqueEnable(tqC), .irq(irqC));

  sle_lamp_viewer viewA (.clk, .lamps(lampA));
  sle_lamp_viewer viewC (.clk, .lamps(lampC));

  // clock of 20 ns
  always #10 clk = ~clk;

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the taken edge
  task automatic rdChk(string nm, logic [7:0] a, logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(nm, rdA, exp);
  endtask : rdChk

  // lamp pattern as text, lamp 0 first: o off, s steady, f flashing
  function automatic logic [21:0] enc(string s);
    logic [21:0] r;
    r = 22'h0;
    for (int i = 0; i < 11; i++) begin
      r[2*i +: 2] = (s[i] == "s") ? 2'h1 : (s[i] == "f") ? 2'h2 : 2'h0;
    end
    return r;
  endfunction : enc

  // let pins cross the synchronisers before looking
  task automatic see(string a, string c);
    logic [21:0] ra, rc;
    repeat (4) @(posedge clk);
    fork
      viewA.observe(ra);
      viewC.observe(rc);
    join
    chk({"access ", a}, 32'(ra), 32'(enc(a)));
    chk({"capacitor ", c}, 32'(rc), 32'(enc(c)));
  endtask : see

  task automatic endSim;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : endSim

  // watchdog, far beyond the roughly 500 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    endSim;
  end

  initial begin
    sle_pkg::sle_dev_state_t ds [5];
    sle_pkg::sle_net_state_t ns [5];
    string du [5];
    string nu [5];
    ds = '{sle_pkg::SLE_DEV_STANDBY, sle_pkg::SLE_DEV_POWER_UP, sle_pkg::SLE_DEV_FAULT,
      sle_pkg::SLE_DEV_FAULT_REACTION, sle_pkg::SLE_DEV_OTHER};
    du = '{"fo", "fo", "os", "os", "oo"};
    ns = '{sle_pkg::SLE_NET_ONLINE, sle_pkg::SLE_NET_INIT_DONE, sle_pkg::SLE_NET_ERROR,
      sle_pkg::SLE_NET_OFF, sle_pkg::SLE_NET_MASTER};
    nu = '{"ss", "of", "os", "oo", "so"};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped space, all pins low
    rdChk("mask", `SLE_ADDR_IRQ_MASK, 32'h0);
    wr(8'h10, 32'hF);
    rdChk("unmapped", 8'h10, 32'h0);
    rdChk("ctrl", `SLE_ADDR_CTRL, 32'h0);
    see("ofooooooooo", "ofooooooooo");
    // healthy running system
    @(posedge clk);
    devState <= sle_pkg::SLE_DEV_OP_ENABLED;
    netState <= sle_pkg::SLE_NET_MASTER;
    {dcLinkPresent, safetySupplyPresent, auxDelivered, capCharged} <= 4'hF;
    portLink <= 3'h7;
    portActivity <= 3'h2;
    see("sossosoosfs", "sosoosossfo");
    // every other device state
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      devState <= ds[i];
      see({du[i], "ssosoosfs"}, {du[i], "soosossfo"});
    end
    // every network condition
    @(posedge clk);
    devState <= sle_pkg::SLE_DEV_OP_ENABLED;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      netState <= ns[i];
      see({"sosso", nu[i], "osfs"}, {"sosoo", nu[i], "ssfo"});
    end
    // DC link lost, then fault on top of it
    @(posedge clk);
    dcLinkPresent <= 1'b0;
    see("ofssosoosfs", "ofsoosossfo");
    @(posedge clk);
    devState <= sle_pkg::SLE_DEV_FAULT;
    see("osssosoosfs", "ossoosossfo");
    // undervoltage, supply gone, capacitors moving, outbound link lost
    @(posedge clk);
    {dcLinkPresent, auxUndervoltage, capCharging} <= 3'h7;
    devState <= sle_pkg::SLE_DEV_OP_ENABLED;
    safetySupplyPresent <= 1'b0;
    portLink <= 3'h3;
    portActivity <= 3'h0;
    see("sooossoosso", "soooosofsso");
    // sticky events, masking and write-one-to-clear
    rdChk("irq status", `SLE_ADDR_IRQ_STATUS, 32'hE);
    chk("cap irq status", rdC, 32'hC);
    chk("irq masked", 32'(irqA), 32'h0);
    wr(`SLE_ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk);
    #1;
    chk("irq raised", 32'(irqA), 32'h1);
    chk("cap irq quiet", 32'(irqC), 32'h0);
    wr(`SLE_ADDR_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    #1;
    chk("irq cleared", 32'(irqA), 32'h0);
    rdChk("irq left", `SLE_ADDR_IRQ_STATUS, 32'hC);
    rdChk("mask back", `SLE_ADDR_IRQ_MASK, 32'h2);
    wr(`SLE_ADDR_STATUS, 32'h0);
    rdChk("status", `SLE_ADDR_STATUS, 32'h41BD);
    wr(`SLE_ADDR_IRQ_STATUS, 32'hC);
    wr(`SLE_ADDR_IRQ_MASK, 32'h1);
    rdChk("irq empty", `SLE_ADDR_IRQ_STATUS, 32'h0);
    // torque cutoff: three edges to act, held until pin low and release write
    @(posedge clk);
    torqueCutoffIn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("torque early", 32'(tqA), 32'h1);
    @(posedge clk);
    #1;
    chk("torque off", 32'(tqA), 32'h0);
    chk("cap torque", 32'(tqC), 32'h0);
    chk("forwarded", 32'(cutA), 32'h1);
    chk("cap forward", 32'(cutC), 32'h0);
    chk("irq cutoff", 32'(irqA), 32'h1);
    chk("cap irq cutoff", 32'(irqC), 32'h1);
    wr(`SLE_ADDR_CTRL, 32'h1);
    rdChk("status cut", `SLE_ADDR_STATUS, 32'h21FD);
    @(posedge clk);
    torqueCutoffIn <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("record held", 32'(tqA), 32'h0);
    wr(`SLE_ADDR_CTRL, 32'h1);
    @(posedge clk);
    #1;
    chk("torque back", 32'(tqA), 32'h1);
    chk("released", 32'(cutA), 32'h0);
    endSim;
  end
endmodule : sle_lamp_encoder_test

`default_nettype wire
